// [logic/tpcg_pkg.sv]
package tpcg_pkg;
  // Input clock divide ratio ahead of the phase generators
  localparam int TPCG_DIV_RATIO = 2;
  // Input oscillator cycles in one state time
  localparam int TPCG_STATE_OSC_CYCLES = 2;
  // Example state time check figures, in kHz and ps
  localparam int TPCG_EXAMPLE_FOSC_KHZ = 16000;
  localparam int TPCG_EXAMPLE_STATE_PS = 125000;
  // Cycles of osc_input lag between internal and pin clock output
  localparam int TPCG_PIN_LAG_CYCLES = 1;
  // Reset values
  localparam logic TPCG_RST_LOW = 1'b0;
  localparam logic [1:0] TPCG_DIV_RST = 2'h0;

  // Operating modes
  typedef enum logic [1:0] {
    TPCG_MODE_RUN,
    TPCG_MODE_IDLE,
    TPCG_MODE_POWERDOWN
  } tpcg_mode_e;

  // Phase clock bundle
  typedef struct packed {
    logic phase_one;
    logic phase_two;
  } tpcg_phases_s;

  // Gated clock bundle delivered to the core
  typedef struct packed {
    logic cpu_phase_one;
    logic cpu_phase_two;
    logic per_phase_one;
    logic per_phase_two;
  } tpcg_gated_s;

  // Phase select for a divider count: low half is phase one
  function automatic tpcg_phases_s tpcg_decode(input logic [1:0] cnt);
    tpcg_phases_s p;
    p.phase_one = (cnt == 2'h0);
    p.phase_two = (cnt == 2'h1);
    return p;
  endfunction : tpcg_decode
endpackage : tpcg_pkg

// [logic/tpcg_divider.sv]
`timescale 1ns/1ps
module tpcg_divider
  import tpcg_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Control
  input wire logic run,
  // Divided phase state
  output logic [1:0] cnt_q
);
  logic [1:0] cnt_reg; // Position within the state time
  logic [1:0] cnt_next;

  // Next divider count; halts at zero when stopped
  always_comb begin
    if (!run) begin
      cnt_next = TPCG_DIV_RST;
    end else if (cnt_reg == 2'(TPCG_DIV_RATIO - 1)) begin
      cnt_next = 2'h0; // Wraps each two input cycles [RULE1]
    end else begin
      cnt_next = cnt_reg + 2'h1;
    end
  end

  // Register the count
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= TPCG_DIV_RST;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign cnt_q = cnt_reg;
endmodule : tpcg_divider

// [logic/tpcg_clock_gen.sv]
`timescale 1ns/1ps
// Functional notes
// (RULE1) Input clock divided by two before phases
// (RULE2) Two active-high phases, never both high
// (RULE3) Phase one rise sets, phase two clears
// (RULE4) Separate CPU and peripheral clock outputs
// (RULE5) Clock output also driven to pin, lagged
// (RULE6) State time equals two input periods
// (RULE7) Idle stops CPU clock, peripherals run
// (RULE8) Powerdown freezes clocks low, oscillator off
module tpcg_clock_gen
  import tpcg_pkg::*;
(
  // Clock and reset; clock is the osc_input rate
  input wire logic clock,
  input wire logic sys_rst,
  // Power management requests
  input wire logic idle_req,
  input wire logic powerdown_req,
  // Phase clocks
  output logic phase_one,
  output logic phase_two,
  // Gated clocks for CPU and peripherals
  output tpcg_gated_s gated,
  // Internal and pin clock output
  output logic clock_output,
  output logic clock_output_pin,
  // Oscillator enable and state time strobe
  output logic osc_enable,
  output logic state_strobe
);
  tpcg_mode_e mode_reg; // Current power mode
  tpcg_mode_e mode_next;
  tpcg_phases_s ph_reg; // Registered phases
  tpcg_phases_s ph_next;
  tpcg_gated_s gated_reg; // Registered gated clocks
  tpcg_gated_s gated_next;
  logic clock_output_reg; // Internal clock output
  logic clock_output_next;
  logic pin_reg; // Pin copy of clock output
  logic pin_next;
  logic osc_reg; // Oscillator enable
  logic osc_next;
  logic strobe_reg; // One pulse per state time
  logic strobe_next;
  logic [1:0] cnt; // Divider position
  tpcg_phases_s ph_dec; // Decoded phases

  // Mode selection; powerdown wins over idle
  always_comb begin
    if (powerdown_req) begin
      mode_next = TPCG_MODE_POWERDOWN;
    end else if (idle_req) begin
      mode_next = TPCG_MODE_IDLE;
    end else begin
      mode_next = TPCG_MODE_RUN;
    end
  end

  // Divider runs except in powerdown, so all clocks freeze
  tpcg_divider u_div (
    .clock(clock),
    .sys_rst(sys_rst),
    .run(mode_reg != TPCG_MODE_POWERDOWN), // [RULE8]
    .cnt_q(cnt)
  );

  // Phase decode from divided count
  always_comb begin
    ph_dec = tpcg_decode(cnt); // Exclusive by decode [RULE2]
  end

  // Next values of phases, gated clocks, clock output
  always_comb begin
    ph_next = '0;
    gated_next = '0;
    clock_output_next = clock_output_reg;
    osc_next = 1'b1;
    strobe_next = 1'b0;
    unique case (mode_reg)
      TPCG_MODE_RUN: begin
        ph_next = ph_dec; // [RULE1] [RULE2]
        gated_next = {ph_dec.phase_one, ph_dec.phase_two,
                      ph_dec.phase_one, ph_dec.phase_two}; // [RULE4]
      end
      TPCG_MODE_IDLE: begin
        ph_next = ph_dec;
        // CPU clocks held low, peripherals keep running [RULE7]
        gated_next = {1'b0, 1'b0, ph_dec.phase_one, ph_dec.phase_two};
      end
      TPCG_MODE_POWERDOWN: begin
        clock_output_next = TPCG_RST_LOW; // Everything low [RULE8]
        osc_next = 1'b0; // [RULE8]
      end
    endcase
    if (mode_reg != TPCG_MODE_POWERDOWN) begin
      // Rising edge of phase one sets, of phase two clears [RULE3]
      if (ph_next.phase_one && !ph_reg.phase_one) begin
        clock_output_next = 1'b1;
      end else if (ph_next.phase_two && !ph_reg.phase_two) begin
        clock_output_next = 1'b0;
      end
      // One strobe per combined phase period [RULE6]
      strobe_next = ph_next.phase_one && !ph_reg.phase_one;
    end
    // Pin follows the internal signal one cycle late [RULE5]
    pin_next = clock_output_reg;
  end

  // Register all state
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mode_reg <= TPCG_MODE_RUN;
      ph_reg <= '0;
      gated_reg <= '0;
      clock_output_reg <= TPCG_RST_LOW;
      pin_reg <= TPCG_RST_LOW;
      osc_reg <= 1'b1;
      strobe_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      ph_reg <= ph_next;
      gated_reg <= gated_next;
      clock_output_reg <= clock_output_next;
      pin_reg <= pin_next;
      osc_reg <= osc_next;
      strobe_reg <= strobe_next;
    end
  end

  // Outputs straight from flip-flops
  assign phase_one = ph_reg.phase_one;
  assign phase_two = ph_reg.phase_two;
  assign gated = gated_reg;
  assign clock_output = clock_output_reg;
  assign clock_output_pin = pin_reg;
  assign osc_enable = osc_reg;
  assign state_strobe = strobe_reg;

  // Checks
  // Check-only helper: cycles since the last state strobe. It saturates, so a
  // long powerdown cannot wrap it round into a falsely short gap.
  logic [2:0] gap_reg; // Zero until the first strobe after reset
  logic [2:0] gap_next;

  // Next gap count; restarts at one after every strobe
  always_comb begin
    if (state_strobe) begin
      gap_next = 3'h1;
    end else if (gap_reg == 3'h0 || gap_reg == 3'h7) begin
      gap_next = gap_reg; // No strobe seen yet, or already saturated
    end else begin
      gap_next = gap_reg + 3'h1;
    end
  end

  // Register the gap count
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      gap_reg <= 3'h0;
    end else begin
      gap_reg <= gap_next;
    end
  end

  // Two cycles in run mode
  sequence s_run2;
    mode_reg == TPCG_MODE_RUN [*2];
  endsequence

  // Powerdown left: the divider restarts from its reset count
  sequence s_pd_exit;
    mode_reg == TPCG_MODE_POWERDOWN ##1 mode_reg != TPCG_MODE_POWERDOWN;
  endsequence

  // Never both phases high
  AST_PHASE_EXCL: assert property (@(posedge clock) disable iff (sys_rst) // [RULE2]
    !(phase_one && phase_two)) else $error("Phases overlap");
  // Exactly one phase high in every cycle while the clocks run
  AST_PHASE_LIVE: assert property (@(posedge clock) disable iff (sys_rst) // [RULE2]
    (mode_reg != TPCG_MODE_POWERDOWN) |=> phase_one != phase_two)
    else $error("No phase active while running");
  // Phase one returns two cycles later unless powerdown cuts in first
  AST_DIV_TWO: assert property (@(posedge clock) disable iff (sys_rst) // [RULE1]
    (s_run2 ##0 $rose(phase_one) ##1 mode_reg != TPCG_MODE_POWERDOWN)
    |-> !phase_one ##1 phase_one) else $error("Phase one not half rate");
  // clock_output registers with the phases, so it is high in the phase one cycle
  AST_CLOCK_OUTPUT_SET: assert property (@(posedge clock) disable iff (sys_rst) // [RULE3]
    $rose(phase_one) |-> clock_output) else $error("Clock output not set");
  AST_CLOCK_OUTPUT_CLR: assert property (@(posedge clock) disable iff (sys_rst) // [RULE3]
    $rose(phase_two) |-> !clock_output) else $error("Clock output not cleared");
  // Pin copy trails the internal signal by the fixed lag
  AST_PIN_LAG: assert property (@(posedge clock) disable iff (sys_rst) // [RULE5]
    ##1 clock_output_pin == $past(clock_output, TPCG_PIN_LAG_CYCLES)) else $error("Pin lag wrong");
  // One strobe every two cycles in steady run
  AST_STATE_TIME: assert property (@(posedge clock) disable iff (sys_rst) // [RULE6]
    (state_strobe ##0 s_run2) |-> !state_strobe ##1 state_strobe)
    else $error("State time not two cycles");
  // The strobe marks the start of phase one
  AST_STROBE_PH1: assert property (@(posedge clock) disable iff (sys_rst) // [RULE6]
    state_strobe |-> phase_one) else $error("Strobe outside phase one");
  // Strobes never come closer than one state time, in any mode
  AST_STROBE_GAP: assert property (@(posedge clock) disable iff (sys_rst) // [RULE6]
    (state_strobe && gap_reg != 3'h0) |-> gap_reg >= 3'(TPCG_STATE_OSC_CYCLES))
    else $error("State time too short");
  // Idle: CPU pair low, peripheral pair follows the phases
  AST_IDLE_CPU: assert property (@(posedge clock) disable iff (sys_rst) // [RULE7]
    (mode_reg == TPCG_MODE_IDLE) |=> !gated.cpu_phase_one && !gated.cpu_phase_two)
    else $error("CPU clock runs in idle");
  AST_IDLE_PER: assert property (@(posedge clock) disable iff (sys_rst) // [RULE7]
    (mode_reg == TPCG_MODE_IDLE && ph_dec.phase_one)
    |=> gated.per_phase_one) else $error("Peripheral clock stopped in idle");
  AST_IDLE_PER_TWO: assert property (@(posedge clock) disable iff (sys_rst) // [RULE7]
    (mode_reg == TPCG_MODE_IDLE && ph_dec.phase_two)
    |=> gated.per_phase_two) else $error("Peripheral phase two stopped in idle");
  // Powerdown: phases, gated clocks and clock output low, oscillator off, divider parked
  AST_PD_FROZEN: assert property (@(posedge clock) disable iff (sys_rst) // [RULE8]
    (mode_reg == TPCG_MODE_POWERDOWN) |=> !osc_enable && !clock_output
    && gated == '0 && !phase_one && !phase_two) else $error("Powerdown not frozen");
  AST_PD_DIV_HOLD: assert property (@(posedge clock) disable iff (sys_rst) // [RULE8]
    (mode_reg == TPCG_MODE_POWERDOWN) |=> cnt == TPCG_DIV_RST)
    else $error("Divider runs in powerdown");
  // Phase one leads after leaving powerdown, so a state time is never split
  AST_PD_EXIT: assert property (@(posedge clock) disable iff (sys_rst) // [RULE1]
    s_pd_exit |=> phase_one && !phase_two)
    else $error("Phase one does not lead after powerdown");
  // Oscillator stays on outside powerdown
  AST_OSC_ON: assert property (@(posedge clock) disable iff (sys_rst) // [RULE8]
    (mode_reg != TPCG_MODE_POWERDOWN) |=> osc_enable)
    else $error("Oscillator off outside powerdown");
  // Run: CPU and peripheral pairs match
  AST_SPLIT: assert property (@(posedge clock) disable iff (sys_rst) // [RULE4]
    (mode_reg == TPCG_MODE_RUN) |=> gated.cpu_phase_one == gated.per_phase_one)
    else $error("CPU and peripheral clocks differ in run");
  AST_SPLIT_TWO: assert property (@(posedge clock) disable iff (sys_rst) // [RULE4]
    (mode_reg == TPCG_MODE_RUN) |=> gated.cpu_phase_two == gated.per_phase_two)
    else $error("CPU and peripheral phase two differ in run");
endmodule : tpcg_clock_gen

// [tb/tpcg_osc_model.sv]
`timescale 1ns/1ps
module tpcg_osc_model (
  // Oscillator control from the device
  input wire logic osc_enable,
  // Clock toward osc_input
  output logic clock
);
  // Free-running source at 200 MHz
  // Keeps running in powerdown, because the device needs edges to sample an exit request
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
endmodule : tpcg_osc_model

// [tb/two_phase_clock_generator_tb.sv]
`timescale 1ns/1ps
module two_phase_clock_generator_tb;
  import tpcg_pkg::*;
  // Stimulus, all driven at the falling edge
  logic clock;
  logic sys_rst = 1'b1;
  logic idle_req = 1'b0;
  logic powerdown_req = 1'b0;
  // Observed outputs
  logic phase_one, phase_two, clock_output, clock_output_pin, osc_enable, state_strobe;
  tpcg_gated_s gated;
  // Scoreboard state
  logic [9:0] exp_q[$];
  logic [9:0] ev; // Oldest note, taken off the queue
  int err_count = 0;
  int check_count = 0;
  int seed = 32'h7F14A0D8;
  int mode;
  // Outputs packed in the same order as the expectation function
  wire logic [9:0] seen = {phase_one, phase_two, gated, clock_output, clock_output_pin,
    osc_enable, state_strobe};

  // Oscillator partner
  tpcg_osc_model u_osc (.osc_enable(osc_enable), .clock(clock));

  // Device under test
  tpcg_clock_gen u_dut (
    .clock(clock), .sys_rst(sys_rst), .idle_req(idle_req), .powerdown_req(powerdown_req),
    .phase_one(phase_one), .phase_two(phase_two), .gated(gated),
    .clock_output(clock_output), .clock_output_pin(clock_output_pin),
    .osc_enable(osc_enable), .state_strobe(state_strobe));

  // Single comparison for the packed output vector
  task cmp(input string what, input logic [9:0] e, input logic [9:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : cmp

  // Expected outputs for mode m, cycle i after a phase one cycle (odd i is phase one)
  function automatic logic [9:0] expv(input int m, input int i);
    logic a, b;
    a = (i % 2 == 1);
    b = !a;
    // Powerdown freezes every clock low and stops the oscillator
    if (m == 2) return 10'h000;
    // Idle drops only the CPU pair; clock output is high with phase one, the pin a cycle later
    return {a, b, (m == 0) ? a : 1'b0, (m == 0) ? b : 1'b0, a, b, a, b, 1'b1, a};
  endfunction : expv

  // Verdict and end of run
  task finish_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  // Monitor: one note taken per cycle once registered outputs have settled
  always @(posedge clock) begin
    #1;
    if (exp_q.size() > 0) begin
      ev = exp_q.pop_front();
      cmp("phases", ev & 10'h3F0, seen & 10'h3F0);
      cmp("clocks", ev & 10'h00F, seen & 10'h00F);
    end
  end

  // Driver: run, idle, powerdown first, then random modes
  initial begin
    repeat (16) @(negedge clock);
    // During reset only the oscillator enable is high
    cmp("reset", 10'h002, seen);
    sys_rst = 1'b0;
    for (int n = 0; n < 16; n++) begin
      mode = (n < 3) ? n : $unsigned($random(seed)) % 3;
      // Idle stays high in powerdown so that the priority is exercised
      idle_req = (mode != 0);
      powerdown_req = (mode == 2);
      repeat (6) @(negedge clock);
      // Align to a phase one cycle, bounded, when the clocks should run
      for (int w = 0; w < 4 && mode != 2 && phase_one !== 1'b1; w++) @(negedge clock);
      for (int i = 0; i < 4; i++) exp_q.push_back(expv(mode, i));
      repeat (5) @(negedge clock);
    end
    finish_test();
  end

  // Watchdog, well beyond the expected 1 us of traffic
  initial begin
    #20000;
    err_count++;
    finish_test();
  end
endmodule : two_phase_clock_generator_tb
